// file: design/pcw_defines.svh
// constants of the clock-config pwm and mcu window register block
//
// Operation
// - bit 0 enables channel pwm generation
// - period length field bits 12:1, 10ns units; counted here in 100 ns clock cycles
// - high time field bits 24:13, 10ns units; counted here in 100 ns clock cycles
// - bit 25 lets channel drive its pin
// - channel four/five/six controls at 0x4C/0x50/0x54
// - window address bits 17:16 choose mcu memory
// - window address bits 15:0 are byte address
// - data write stores four bytes to memory; here only the bytes set in pstrb
// - data read fetches four bytes from memory
// - three scratch registers, reset zero, no effect
// - reserved fields are storage with documented resets
`ifndef PCW_DEFINES_SVH
`define PCW_DEFINES_SVH

// printed offsets are register indices; byte address is four times the index
`define PCW_IDX_PWM4          8'h4c
`define PCW_IDX_PWM5          8'h50
`define PCW_IDX_PWM6          8'h54
`define PCW_IDX_MEM_SPEED     8'h58
`define PCW_IDX_IOC_DELAY     8'h5c
`define PCW_IDX_WIN_ADDR      8'h60
`define PCW_IDX_WIN_DATA      8'h64
`define PCW_IDX_BIU_STOP      8'h68
`define PCW_IDX_PLL_REG       8'h6c
`define PCW_IDX_CPLL3         8'h70
`define PCW_IDX_GC_CLK        8'h74
`define PCW_IDX_SCRATCH1      8'h78
`define PCW_IDX_SCRATCH2      8'h7c
`define PCW_IDX_DATA_DLL      8'h80
`define PCW_IDX_SCRATCH       8'h84
`define PCW_IDX_ACMD_DLL_A    8'h88
`define PCW_IDX_ACMD_DLL_B    8'h89

// pwm control field positions
`define PCW_PWM_EN_BIT        0
`define PCW_PWM_PER_LSB       1
`define PCW_PWM_PER_MSB       12
`define PCW_PWM_HIGH_LSB      13
`define PCW_PWM_HIGH_MSB      24
`define PCW_PWM_OE_BIT        25
`define PCW_PWM_MASK          32'h03ffffff

// window address layout
`define PCW_WIN_SPACE_MSB     17
`define PCW_WIN_SPACE_LSB     16
`define PCW_WIN_BYTE_MSB      15
`define PCW_WIN_ADDR_MASK     32'h0003ffff
`define PCW_SPACE_DATA        2'b00
`define PCW_SPACE_INSTR       2'b01
`define PCW_SPACE_UNDEF       2'b10
`define PCW_SPACE_CONFIG      2'b11

// writable masks and reset values of storage registers
`define PCW_MEM_SPEED_MASK    32'h00000007
`define PCW_IOC_DELAY_MASK    32'h000003ff
`define PCW_IOC_DELAY_RST     32'h00000042
`define PCW_BIU_STOP_MASK     32'h0003ffff
`define PCW_BIU_STOP_RST      32'h0003109f
`define PCW_PLL_REG_MASK      32'h000000f3
`define PCW_PLL_REG_RST       32'h00000080
`define PCW_CPLL3_RST         32'h02000001
`define PCW_GC_CLK_MASK       32'h00000001
`define PCW_BYTE_MASK         32'h000000ff
`define PCW_FULL_MASK         32'hffffffff

// timing: one pwm unit is 10 ns, clock period 100 ns, least time rounds up
`define PCW_PWM_UNIT_NS       10
`define PCW_CLK_PERIOD_NS     100
`define PCW_TICK_CYCLES  ((`PCW_PWM_UNIT_NS + `PCW_CLK_PERIOD_NS - 1) / `PCW_CLK_PERIOD_NS)

`endif

// file: design/pcw_pkg.sv
// types shared by the clock-config pwm and mcu window block
package pcw_pkg;

	typedef enum logic [1:0] {
		PCW_BUS_IDLE     = 2'b00,
		PCW_BUS_MEM_WAIT = 2'b01,
		PCW_BUS_DONE     = 2'b10
	} pcw_bus_state_t;

	typedef logic [1:0] pcw_space_t;

endpackage

// file: design/pcw_top.sv
// clock-config register bank: pwm channels four to six and mcu memory window
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`include "pcw_defines.svh"

module pcw_top #(
	parameter int ADDR_W      = 12,
	parameter int TICK_CYCLES = `PCW_TICK_CYCLES
) (
	input  wire logic                core_clk,
	input  wire logic                reset,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	output logic                     mcuMemReq,
	output logic                     mcuMemWrite,
	output pcw_pkg::pcw_space_t      mcuMemSpace,
	output logic [15:0]              mcuMemAddr,
	output logic [31:0]              mcuMemWdata,
	output logic [3:0]               mcuMemByteEn,
	input  wire logic                mcuMemAck,
	input  wire logic [31:0]         mcuMemRdata,
	output logic [2:0]               pwmPinOut,
	output logic [2:0]               pwmPinOe
);
	import pcw_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// merge write data into a register under byte strobes and a writable mask
	function automatic logic [31:0] mergeBytes(
		input logic [31:0] old,
		input logic [31:0] wdata,
		input logic [3:0]  strb,
		input logic [31:0] mask
	);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = wdata[8*b +: 8];
			end
		end
		return res & mask;
	endfunction

	// register index of an aligned word address, or a value no register uses
	function automatic logic [8:0] wordIndex(input logic [ADDR_W-1:0] addr);
		logic [8:0] idx;
		idx = 9'h100;
		if (addr[1:0] == 2'b00 && addr[ADDR_W-1:10] == '0) begin
			idx = {1'b0, addr[9:2]};
		end
		return idx;
	endfunction

	// true when the access index names the register at this printed index
	function automatic logic hitsIndex(input logic [8:0] acc, input logic [7:0] idx);
		return acc == {1'b0, idx};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// register storage

	logic [31:0]    pwmCtrl [3];
	logic [31:0]    memSpeed;
	logic [31:0]    iocDelay;
	logic [31:0]    winAddr;
	logic [31:0]    biuStop;
	logic [31:0]    pllReg;
	logic [31:0]    cpll3;
	logic [31:0]    gcClk;
	logic [31:0]    scratch1;
	logic [31:0]    scratch2;
	logic [31:0]    dataDll;
	logic [31:0]    scratch0;
	logic [31:0]    acmdDllA;
	logic [31:0]    acmdDllB;

	pcw_bus_state_t busState;
	logic [8:0]     accIdx;
	logic           accessPending;
	logic           wrCommit;
	logic           regMapped;
	logic [31:0]    readMux;
	pcw_space_t     winSpace;

	assign accIdx        = wordIndex(paddr);
	assign accessPending = psel && penable && !pready;
	// the write lands at the edge where the master sees pready high
	assign wrCommit      = psel && penable && pready && pwrite;
	assign winSpace      = winAddr[`PCW_WIN_SPACE_MSB:`PCW_WIN_SPACE_LSB];

	// pwm controls share one layout, so one loop writes all three
	for (genvar ch = 0; ch < 3; ch++) begin : g_pwm_reg
		localparam logic [8:0] CH_IDX = {1'b0, `PCW_IDX_PWM4} + 9'(4 * ch);
		always_ff @(posedge core_clk) begin
			if (reset) begin
				pwmCtrl[ch] <= 32'h00000000;
			end else if (wrCommit && accIdx == CH_IDX) begin
				pwmCtrl[ch] <= mergeBytes(pwmCtrl[ch], pwdata, pstrb, `PCW_PWM_MASK);
			end
		end
	end

	// storage-only registers load their reset values on reset, take writes and steer nothing
	always_ff @(posedge core_clk) begin
		if (reset) begin
			memSpeed <= 32'h00000000;
			iocDelay <= `PCW_IOC_DELAY_RST;
			biuStop  <= `PCW_BIU_STOP_RST;
			pllReg   <= `PCW_PLL_REG_RST;
			cpll3    <= `PCW_CPLL3_RST;
			gcClk    <= 32'h00000000;
			dataDll  <= 32'h00000000;
			acmdDllA <= 32'h00000000;
			acmdDllB <= 32'h00000000;
		end else if (wrCommit) begin
			case (accIdx)
				{1'b0, `PCW_IDX_MEM_SPEED}: begin
					memSpeed <= mergeBytes(memSpeed, pwdata, pstrb, `PCW_MEM_SPEED_MASK);
				end
				{1'b0, `PCW_IDX_IOC_DELAY}: begin
					iocDelay <= mergeBytes(iocDelay, pwdata, pstrb, `PCW_IOC_DELAY_MASK);
				end
				{1'b0, `PCW_IDX_BIU_STOP}: begin
					biuStop <= mergeBytes(biuStop, pwdata, pstrb, `PCW_BIU_STOP_MASK);
				end
				{1'b0, `PCW_IDX_PLL_REG}: begin
					pllReg <= mergeBytes(pllReg, pwdata, pstrb, `PCW_PLL_REG_MASK);
				end
				{1'b0, `PCW_IDX_CPLL3}: begin
					cpll3 <= mergeBytes(cpll3, pwdata, pstrb, `PCW_FULL_MASK);
				end
				{1'b0, `PCW_IDX_GC_CLK}: begin
					// power state and stop request bits stay zero
					gcClk <= mergeBytes(gcClk, pwdata, pstrb, `PCW_GC_CLK_MASK);
				end
				{1'b0, `PCW_IDX_DATA_DLL}: begin
					dataDll <= mergeBytes(dataDll, pwdata, pstrb, `PCW_FULL_MASK);
				end
				{1'b0, `PCW_IDX_ACMD_DLL_A}: begin
					acmdDllA <= mergeBytes(acmdDllA, pwdata, pstrb, `PCW_BYTE_MASK);
				end
				{1'b0, `PCW_IDX_ACMD_DLL_B}: begin
					acmdDllB <= mergeBytes(acmdDllB, pwdata, pstrb, `PCW_BYTE_MASK);
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			scratch1 <= 32'h00000000;
			scratch2 <= 32'h00000000;
			scratch0 <= 32'h00000000;
		end else if (wrCommit) begin
			case (accIdx)
				{1'b0, `PCW_IDX_SCRATCH1}: begin
					scratch1 <= mergeBytes(scratch1, pwdata, pstrb, `PCW_FULL_MASK);
				end
				{1'b0, `PCW_IDX_SCRATCH2}: begin
					scratch2 <= mergeBytes(scratch2, pwdata, pstrb, `PCW_FULL_MASK);
				end
				{1'b0, `PCW_IDX_SCRATCH}: begin
					scratch0 <= mergeBytes(scratch0, pwdata, pstrb, `PCW_FULL_MASK);
				end
				default: begin
				end
			endcase
		end
	end

	// spare bits 31:18 of the window address read back as zero
	always_ff @(posedge core_clk) begin
		if (reset) begin
			winAddr <= 32'h00000000;
		end else if (wrCommit && hitsIndex(accIdx, `PCW_IDX_WIN_ADDR)) begin
			winAddr <= mergeBytes(winAddr, pwdata, pstrb, `PCW_WIN_ADDR_MASK);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read decode

	always_comb begin
		readMux   = 32'h00000000;
		regMapped = 1'b1;
		case (accIdx)
			{1'b0, `PCW_IDX_PWM4}:       readMux = pwmCtrl[0];
			{1'b0, `PCW_IDX_PWM5}:       readMux = pwmCtrl[1];
			{1'b0, `PCW_IDX_PWM6}:       readMux = pwmCtrl[2];
			{1'b0, `PCW_IDX_MEM_SPEED}:  readMux = memSpeed;
			{1'b0, `PCW_IDX_IOC_DELAY}:  readMux = iocDelay;
			{1'b0, `PCW_IDX_WIN_ADDR}:   readMux = winAddr;
			{1'b0, `PCW_IDX_WIN_DATA}:   readMux = 32'h00000000;
			{1'b0, `PCW_IDX_BIU_STOP}:   readMux = biuStop;
			{1'b0, `PCW_IDX_PLL_REG}:    readMux = pllReg;
			{1'b0, `PCW_IDX_CPLL3}:      readMux = cpll3;
			{1'b0, `PCW_IDX_GC_CLK}:     readMux = gcClk;
			{1'b0, `PCW_IDX_SCRATCH1}:   readMux = scratch1;
			{1'b0, `PCW_IDX_SCRATCH2}:   readMux = scratch2;
			{1'b0, `PCW_IDX_DATA_DLL}:   readMux = dataDll;
			{1'b0, `PCW_IDX_SCRATCH}:    readMux = scratch0;
			{1'b0, `PCW_IDX_ACMD_DLL_A}: readMux = acmdDllA;
			{1'b0, `PCW_IDX_ACMD_DLL_B}: readMux = acmdDllB;
			default:                     regMapped = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb answer and mcu memory window

	// the window data access stalls pready until the memory acknowledges;
	// the undefined space 2'b10 is refused without touching memory
	logic winDataHit;
	logic memAccess;
	logic regAnswer;
	logic memStart;
	logic memAnswer;

	assign winDataHit = hitsIndex(accIdx, `PCW_IDX_WIN_DATA);
	assign memAccess  = winDataHit && winSpace != `PCW_SPACE_UNDEF;
	assign regAnswer  = busState == PCW_BUS_IDLE && accessPending && !memAccess;
	assign memStart   = busState == PCW_BUS_IDLE && accessPending && memAccess;
	assign memAnswer  = busState == PCW_BUS_MEM_WAIT && mcuMemAck;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			busState <= PCW_BUS_IDLE;
		end else begin
			case (busState)
				PCW_BUS_IDLE: begin
					if (memStart) begin
						busState <= PCW_BUS_MEM_WAIT;
					end else if (regAnswer) begin
						busState <= PCW_BUS_DONE;
					end
				end
				PCW_BUS_MEM_WAIT: begin
					if (mcuMemAck) begin
						busState <= PCW_BUS_DONE;
					end
				end
				PCW_BUS_DONE: begin
					busState <= PCW_BUS_IDLE;
				end
				default: begin
					busState <= PCW_BUS_IDLE;
				end
			endcase
		end
	end

	// pready and pslverr stand for exactly one cycle, so the master never
	// sees a stale answer at the start of its next transfer
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (regAnswer) begin
			pready  <= 1'b1;
			pslverr <= !regMapped || winDataHit;
		end else begin
			pready  <= memAnswer;
			pslverr <= 1'b0;
		end
	end

	// read data is zero outside the answer cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			prdata <= 32'h00000000;
		end else if (regAnswer && !pwrite) begin
			prdata <= readMux;
		end else if (memAnswer && !mcuMemWrite) begin
			prdata <= mcuMemRdata;
		end else begin
			prdata <= 32'h00000000;
		end
	end

	// request fields stand from the request until the acknowledge edge
	always_ff @(posedge core_clk) begin
		if (reset) begin
			mcuMemReq    <= 1'b0;
			mcuMemWrite  <= 1'b0;
			mcuMemSpace  <= `PCW_SPACE_DATA;
			mcuMemAddr   <= 16'h0000;
			mcuMemWdata  <= 32'h00000000;
			mcuMemByteEn <= 4'h0;
		end else if (memStart) begin
			mcuMemReq    <= 1'b1;
			mcuMemWrite  <= pwrite;
			mcuMemSpace  <= winSpace;
			mcuMemAddr   <= winAddr[`PCW_WIN_BYTE_MSB:0];
			mcuMemWdata  <= pwdata;
			mcuMemByteEn <= pwrite ? pstrb : 4'hf;
		end else if (memAnswer || busState != PCW_BUS_MEM_WAIT) begin
			mcuMemReq <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pwm generation

	// one tick per 10 ns unit; the unit is shorter than the clock so it
	// stretches to the minimum of one cycle, which slows the pwm by the ratio
	logic [7:0] tickCnt;
	logic       tickPulse;

	assign tickPulse = (tickCnt == 8'(TICK_CYCLES - 1));

	always_ff @(posedge core_clk) begin
		if (reset) begin
			tickCnt <= 8'h00;
		end else if (tickPulse) begin
			tickCnt <= 8'h00;
		end else begin
			tickCnt <= tickCnt + 8'h01;
		end
	end

	for (genvar ch = 0; ch < 3; ch++) begin : g_pwm
		logic [11:0] phase;
		logic [11:0] period;
		logic [11:0] highTime;
		logic        chanEn;
		logic [12:0] next_phase;

		assign chanEn     = pwmCtrl[ch][`PCW_PWM_EN_BIT];
		assign period     = pwmCtrl[ch][`PCW_PWM_PER_MSB:`PCW_PWM_PER_LSB];
		assign highTime   = pwmCtrl[ch][`PCW_PWM_HIGH_MSB:`PCW_PWM_HIGH_LSB];
		assign next_phase = {1'b0, phase} + 13'h0001;

		// a shortened period restarts the phase at once instead of wrapping
		always_ff @(posedge core_clk) begin
			if (reset) begin
				phase <= 12'h000;
			end else if (!chanEn) begin
				phase <= 12'h000;
			end else if (tickPulse) begin
				if (next_phase >= {1'b0, period}) begin
					phase <= 12'h000;
				end else begin
					phase <= next_phase[11:0];
				end
			end
		end

		always_ff @(posedge core_clk) begin
			if (reset) begin
				pwmPinOut[ch] <= 1'b0;
			end else begin
				pwmPinOut[ch] <= chanEn && period != 12'h000 && phase < highTime;
			end
		end

		// the enable follows bit 25 alone, so a disabled channel can still
		// hold its pin driven low
		always_ff @(posedge core_clk) begin
			if (reset) begin
				pwmPinOe[ch] <= 1'b0;
			end else begin
				pwmPinOe[ch] <= pwmCtrl[ch][`PCW_PWM_OE_BIT];
			end
		end
	end

endmodule

// file: testbench/pcw_top_chk.sv
// port assertions for the pwm and mcu window register block
`timescale 1ns/10ps
module pcw_top_chk #(
	parameter int ADDR_W = 12
) (
	input wire logic			core_clk,
	input wire logic			reset,
	input wire logic			psel,
	input wire logic			penable,
	input wire logic			pwrite,
	input wire logic [ADDR_W-1:0]	paddr,
	input wire logic [31:0]		pwdata,
	input wire logic [31:0]		prdata,
	input wire logic			pready,
	input wire logic			pslverr,
	input wire logic			mcuMemReq,
	input wire logic			mcuMemWrite,
	input wire pcw_pkg::pcw_space_t	mcuMemSpace,
	input wire logic [15:0]		mcuMemAddr,
	input wire logic			mcuMemAck,
	input wire logic [31:0]		mcuMemRdata,
	input wire logic [2:0]		pwmPinOut,
	input wire logic [2:0]		pwmPinOe
);
	import pcw_pkg::*;
	logic [31:0]	ctl4;
	// shadow of channel four; the bench only writes that channel with whole words
	always_ff @(posedge core_clk) begin
		if (reset)
			ctl4 <= 32'h0;
		else if (psel && penable && pready && pwrite && !pslverr && paddr == ADDR_W'(12'h130))
			ctl4 <= pwdata & 32'h03ffffff;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////////
	property p_rdy;
		pready |=> !pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("pready too long");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("pslverr without pready");
	property p_hold;
		mcuMemReq && !mcuMemAck |=> mcuMemReq && $stable({mcuMemSpace, mcuMemAddr, mcuMemWrite});
	endproperty
	a_hold: assert property (p_hold) else $error("memory request moved");
	property p_done;
		mcuMemReq && mcuMemAck |=> !mcuMemReq && pready;
	endproperty
	a_done: assert property (p_done) else $error("memory completion");
	property p_rd;
		mcuMemReq && mcuMemAck && !mcuMemWrite |=> prdata == $past(mcuMemRdata);
	endproperty
	a_rd: assert property (p_rd) else $error("window read data");
	property p_space;
		mcuMemReq |-> mcuMemSpace != 2'b10;
	endproperty
	a_space: assert property (p_space) else $error("undefined space used");
	property p_oe;
		$stable(ctl4) [*3] |-> pwmPinOe[0] == ctl4[25];
	endproperty
	a_oe: assert property (p_oe) else $error("output enable");
	property p_dis;
		!ctl4[0] [*4] |-> !pwmPinOut[0];
	endproperty
	a_dis: assert property (p_dis) else $error("pin high while off");
	property p_zero;
		$stable(ctl4) [*4] ##0 (ctl4[24:13] == 12'h0 || ctl4[12:1] == 12'h0) |-> !pwmPinOut[0];
	endproperty
	a_zero: assert property (p_zero) else $error("pin high with zero count");
endmodule

bind pcw_top pcw_top_chk #(.ADDR_W(ADDR_W)) i_chk (.core_clk(core_clk), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .mcuMemReq(mcuMemReq),
	.mcuMemWrite(mcuMemWrite), .mcuMemSpace(mcuMemSpace), .mcuMemAddr(mcuMemAddr),
	.mcuMemAck(mcuMemAck), .mcuMemRdata(mcuMemRdata), .pwmPinOut(pwmPinOut),
	.pwmPinOe(pwmPinOe));

// file: testbench/testbench.sv
// self-checking bench for the pwm and mcu window register block
`timescale 1ns/10ps
module testbench;
	import pcw_pkg::*;
	logic		core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, erv;
	logic [11:0]	paddr = 12'h0;
	logic [31:0]	pwdata = 32'h0, prdata, mcuMemWdata, mcuMemRdata = 32'h0, rdv;
	logic [3:0]	mcuMemByteEn, pstrb = 4'hf;
	logic		pready, pslverr, mcuMemReq, mcuMemWrite, mcuMemAck = 0, lastWr;
	pcw_space_t	mcuMemSpace;
	logic [15:0]	mcuMemAddr;
	logic [2:0]	pwmPinOut, pwmPinOe;
	logic [31:0]	mem[logic [17:0]];
	logic [17:0]	lastLoc;
	int		nErrors = 0, totalChecks = 0, memOps = 0, ackDelay = 0, wt = 0;
	localparam pcw_space_t SP[3] = '{2'b00, 2'b01, 2'b11};
	localparam logic [31:0] RM[16] = '{32'h3ffffff, 32'h3ffffff, 32'h3ffffff, 32'h7,
		32'h3ff, 32'h3ffff, 32'h3ffff, 32'hf3, 32'hffffffff, 32'h1, 32'hffffffff,
		32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hff, 32'hff};

	pcw_top #(.ADDR_W(12), .TICK_CYCLES(1)) i_dut (.core_clk(core_clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mcuMemReq(mcuMemReq), .mcuMemWrite(mcuMemWrite), .mcuMemSpace(mcuMemSpace),
		.mcuMemAddr(mcuMemAddr), .mcuMemWdata(mcuMemWdata), .mcuMemByteEn(mcuMemByteEn),
		.mcuMemAck(mcuMemAck), .mcuMemRdata(mcuMemRdata), .pwmPinOut(pwmPinOut),
		.pwmPinOe(pwmPinOe));

	always #50 core_clk = ~core_clk;

	// memory answers after ackDelay cycles; its data lines toggle when idle
	always @(posedge core_clk) begin
		if (mcuMemReq === 1'b1 && !mcuMemAck && wt >= ackDelay) begin
			mcuMemAck <= 1'b1;
			mcuMemRdata <= mem[{mcuMemSpace, mcuMemAddr}];
			lastLoc <= {mcuMemSpace, mcuMemAddr};
			lastWr <= mcuMemWrite;
			memOps <= memOps + 1;
			wt <= 0;
			if (mcuMemWrite && mcuMemByteEn === 4'hf)
				mem[{mcuMemSpace, mcuMemAddr}] = mcuMemWdata;
		end else begin
			mcuMemAck <= 1'b0;
			mcuMemRdata <= ~mcuMemRdata;
			wt <= (mcuMemReq === 1'b1 && !mcuMemAck) ? wt + 1 : 0;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task chk(input logic ok, input string m);
		totalChecks++;
		if (ok !== 1'b1) begin
			nErrors++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask

	task report_and_stop;
		$display("checks %0d errors %0d", totalChecks, nErrors);
		if (nErrors == 0 && totalChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			nErrors++;
			report_and_stop;
		end
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task t_regs;
		logic [11:0] a;
		logic [31:0] v;
		for (int i = 0; i < 16; i++) begin
			a = i < 6 ? 12'h130 + 12'(16 * i) : (i < 15 ? 12'h140 + 12'(16 * i) : 12'h224);
			v = i == 4 ? 32'h42 : i == 6 ? 32'h3109f : i == 7 ? 32'h80 : 32'h0;
			acc(1'b0, a, 32'h0);
			chk(rdv === (i == 8 ? 32'h02000001 : v), "reset value");
			acc(1'b1, a, 32'hffffffff);
			acc(1'b0, a, 32'h0);
			chk(rdv === RM[i] && erv === 1'b0, "writable bits");
			acc(1'b1, a, 32'h0);
		end
	endtask

	task t_bad;
		acc(1'b0, 12'h004, 32'h0);
		chk(erv === 1'b1 && rdv === 32'h0, "unmapped read");
		acc(1'b1, 12'h131, 32'h1);
		chk(erv === 1'b1, "misaligned write accepted");
		acc(1'b0, 12'h130, 32'h0);
		chk(rdv === 32'h0, "misaligned write landed");
		acc(1'b1, 12'h1e0, 32'h11223344);
		pstrb <= 4'h4;
		acc(1'b1, 12'h1e0, 32'haabbccdd);
		pstrb <= 4'hf;
		acc(1'b0, 12'h1e0, 32'h0);
		chk(rdv === 32'h11bb3344, "byte strobe merge");
	endtask

	task t_win;
		int ops;
		logic [31:0] v;
		foreach (SP[k]) begin
			ackDelay = k * 2;
			v = 32'hc3a50000 + 32'(k);
			acc(1'b1, 12'h180, {14'h0, SP[k], 16'h0104 + 16'(k)});
			ops = memOps;
			acc(1'b1, 12'h190, v);
			chk(memOps == ops + 1 && lastWr === 1'b1 && mem[lastLoc] === v, "win write");
			chk(lastLoc === {SP[k], 16'h0104 + 16'(k)}, "win place");
			acc(1'b0, 12'h190, 32'h0);
			chk(rdv === v && lastWr === 1'b0, "win read");
		end
		ops = memOps;
		acc(1'b1, 12'h180, 32'h00020000);
		acc(1'b0, 12'h190, 32'h0);
		chk(erv === 1'b1 && memOps == ops, "undefined space");
	endtask

	task t_pwm;
		int n;
		for (int c = 0; c < 3; c++) begin
			acc(1'b1, 12'h130 + 12'(c * 16), 32'h02000009 | 32'((c + 1) << 13));
			repeat (4) @(posedge core_clk);
			n = 0;
			repeat (8) begin
				@(posedge core_clk);
				n += int'(pwmPinOut[c] === 1'b1);
			end
			chk(n == 2 * (c + 1) && pwmPinOe[c] === 1'b1, "pwm duty");
			acc(1'b1, 12'h130 + 12'(c * 16), 32'h0);
			repeat (4) @(posedge core_clk);
			chk(pwmPinOut[c] === 1'b0 && pwmPinOe[c] === 1'b0, "pwm off");
		end
	endtask

	initial begin
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		t_regs;
		t_bad;
		t_win;
		t_pwm;
		report_and_stop;
	end
endmodule
